// *** rtl/sai_pkg.sv ***
// Purpose: shared constants for the switch array serial target and its controller
// Assumes: 7-bit addressing, 16-bit write word, 16-bit status word
// Notes:   address upper bits fixed, lower two from select pins
package sai_pkg;
   localparam logic [4:0] ADDR_FIXED      = 5'h14;
   localparam int         ADDR_W          = 7;
   localparam int         BYTE_W          = 8;
   localparam int         WORD_W          = 16;
   localparam logic [3:0] BIT_LAST        = 4'h7;
   localparam logic [3:0] ACK_SLOT        = 4'h8;
   localparam logic [3:0] CNT_ARMED       = 4'hf;
   localparam int         LOAD_BIT_POS    = 1;
   localparam int         SRST_BIT_POS    = 0;
   localparam logic [15:0] STATUS_RESET   = 16'h0000;
   localparam logic [2:0] SYNC_RESET      = 3'h7;
   localparam logic [7:0] HALF_DIV        = 8'h04;

   typedef enum logic [4:0] {
      T_IDLE = 5'b00001,
      T_ADDR = 5'b00010,
      T_WR   = 5'b00100,
      T_RD   = 5'b01000,
      T_SKIP = 5'b10000
   } sai_tgt_state_type;

   typedef enum logic [5:0] {
      C_IDLE  = 6'b000001,
      C_START = 6'b000010,
      C_LOW   = 6'b000100,
      C_HIGH  = 6'b001000,
      C_STOPA = 6'b010000,
      C_STOPB = 6'b100000
   } sai_ctl_state_type;
endpackage

// *** rtl/sai_bus_if.sv ***
// Purpose: two-wire open-drain link between controller and target
// Assumes: pull-ups modelled here: a line is high unless some end drives it
// Notes:   target never drives the clock line
interface sai_bus_if;
   logic scl_o;
   logic scl_oe;
   logic sda_ctl_o;
   logic sda_ctl_oe;
   logic sda_tgt_o;
   logic sda_tgt_oe;
   logic scl_i;
   logic sda_i;

   assign scl_i = ~(scl_oe & ~scl_o);
   assign sda_i = ~((sda_ctl_oe & ~sda_ctl_o) | (sda_tgt_oe & ~sda_tgt_o));

   modport target (input scl_i, input sda_i, output sda_tgt_o, output sda_tgt_oe);
   modport controller (input scl_i, input sda_i, output scl_o, output scl_oe,
                       output sda_ctl_o, output sda_ctl_oe);
endinterface

// *** rtl/sai_target.sv ***
// Purpose: serial target front end of a six-channel 2:1 switch array
// Assumes: controller on the far side drives the clock; lines sampled by clk
// Notes:   command decode lives downstream; this block hands over the word
// Function
// - target only, never drives clock line
// - start: data falls while clock high
// - after start shift eight bits MSB first
// - acknowledge own address on ninth pulse
// - direction one sends, zero receives
// - address mismatch: stay idle, data released
// - every byte nine pulses, ack by receiver
// - data changes only while clock low
// - data rising while clock high ends transfer
// - controller ends transfer with stop
// - write stop on tenth pulse after ack
// - read: nack, then stop on tenth
// - five fixed address bits, two from pins
// - write carries command then control byte
// - read returns two status bytes, first acked, last nacked
// - pending commands applied when load flag set
// - soft reset low or power-up: all off
module sai_target (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rstn,
   // link
   sai_bus_if.target                      bus,
   // address select pins
   input  wire logic                      addr_select_low,
   input  wire logic                      addr_select_high,
   // switch array side
   input  wire logic [sai_pkg::WORD_W-1:0] status_word,
   output logic      [sai_pkg::WORD_W-1:0] cmd_word,
   output logic                           cmd_valid,
   output logic                           load_switch_flag,
   output logic                           soft_reset_n_bit,
   output logic                           clear_all
);
   // ----------------------------------------------------------------
   // line synchronisers
   // ----------------------------------------------------------------
   logic [2:0] scl_sync_reg, scl_sync_next;
   logic [2:0] sda_sync_reg, sda_sync_next;
   logic       scl_reg, scl_next, sda_reg, sda_next;
   // select pins are static but still come in from outside
   logic [2:0] asl_sync_reg, asl_sync_next, ash_sync_reg, ash_sync_next;
   logic       asl_reg, asl_next, ash_reg, ash_next;

   always_comb begin
      scl_sync_next = {scl_sync_reg[1:0], bus.scl_i};
      sda_sync_next = {sda_sync_reg[1:0], bus.sda_i};
      scl_next      = (scl_sync_reg[2] == scl_sync_reg[1]) ? scl_sync_reg[2] : scl_reg;
      sda_next      = (sda_sync_reg[2] == sda_sync_reg[1]) ? sda_sync_reg[2] : sda_reg;
      asl_sync_next = {asl_sync_reg[1:0], addr_select_low};
      ash_sync_next = {ash_sync_reg[1:0], addr_select_high};
      asl_next      = (asl_sync_reg[2] == asl_sync_reg[1]) ? asl_sync_reg[2] : asl_reg;
      ash_next      = (ash_sync_reg[2] == ash_sync_reg[1]) ? ash_sync_reg[2] : ash_reg;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_sync_reg <= sai_pkg::SYNC_RESET;
         asl_sync_reg <= 3'h0;
         ash_sync_reg <= 3'h0;
         asl_reg      <= 1'b0;
         ash_reg      <= 1'b0;
         sda_sync_reg <= sai_pkg::SYNC_RESET;
         scl_reg      <= 1'b1;
         sda_reg      <= 1'b1;
      end else begin
         scl_sync_reg <= scl_sync_next;
         asl_sync_reg <= asl_sync_next;
         ash_sync_reg <= ash_sync_next;
         asl_reg      <= asl_next;
         ash_reg      <= ash_next;
         sda_sync_reg <= sda_sync_next;
         scl_reg      <= scl_next;
         sda_reg      <= sda_next;
      end
   end

   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = scl_next & ~scl_reg;
   assign scl_fall = ~scl_next & scl_reg;
   assign start_ev = scl_reg & scl_next & sda_reg & ~sda_next;
   assign stop_ev  = scl_reg & scl_next & ~sda_reg & sda_next;

   // ----------------------------------------------------------------
   // byte engine
   // ----------------------------------------------------------------
   sai_pkg::sai_tgt_state_type state_reg, state_next;
   logic [3:0]                 cnt_reg, cnt_next;
   logic [7:0]                 shift_reg, shift_next;
   logic                       byte2_reg, byte2_next;
   logic [7:0]                 cmd_hold_reg, cmd_hold_next;
   logic                       drive_reg, drive_next;
   logic                       nacked_reg, nacked_next;
   logic [sai_pkg::WORD_W-1:0] cmd_word_reg, cmd_word_next;
   logic                       valid_reg, valid_next;
   logic                       load_reg, load_next, srst_reg, srst_next, clr_reg, clr_next;
   logic [6:0]                 own_addr;

   assign own_addr = {sai_pkg::ADDR_FIXED, ash_reg, asl_reg};

   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      shift_next    = shift_reg;
      byte2_next    = byte2_reg;
      cmd_hold_next = cmd_hold_reg;
      drive_next    = drive_reg;
      nacked_next   = nacked_reg;
      cmd_word_next = cmd_word_reg;
      valid_next    = 1'b0;
      clr_next      = 1'b0;
      load_next     = load_reg;
      srst_next     = srst_reg;
      if (start_ev) begin
         // partial byte dropped, fresh address phase
         state_next = sai_pkg::T_ADDR;
         // clock fall that follows the start carries no bit
         cnt_next   = sai_pkg::CNT_ARMED;
         drive_next = 1'b0;
      end else if (stop_ev) begin
         state_next = sai_pkg::T_IDLE;
         drive_next = 1'b0;
      end else begin
         case (state_reg)
            sai_pkg::T_IDLE, sai_pkg::T_SKIP: begin
               drive_next = 1'b0;
            end
            sai_pkg::T_ADDR, sai_pkg::T_WR: begin
               if (scl_rise && cnt_reg <= sai_pkg::BIT_LAST) begin
                  shift_next = {shift_reg[6:0], sda_reg};
               end
               if (scl_fall) begin
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == sai_pkg::BIT_LAST) begin
                     if (state_reg == sai_pkg::T_ADDR && shift_reg[7:1] != own_addr) begin
                        state_next = sai_pkg::T_SKIP;
                     end else begin
                        drive_next = 1'b1;
                        if (state_reg == sai_pkg::T_WR) begin
                           if (!byte2_reg) begin
                              cmd_hold_next = shift_reg;
                           end else begin
                              cmd_word_next = {cmd_hold_reg, shift_reg};
                              valid_next    = 1'b1;
                              load_next     = shift_reg[sai_pkg::LOAD_BIT_POS];
                              srst_next     = shift_reg[sai_pkg::SRST_BIT_POS];
                              clr_next      = ~shift_reg[sai_pkg::SRST_BIT_POS];
                           end
                           byte2_next = ~byte2_reg;
                        end
                     end
                  end else if (cnt_reg == sai_pkg::ACK_SLOT) begin
                     cnt_next   = 4'h0;
                     drive_next = 1'b0;
                     if (state_reg == sai_pkg::T_ADDR) begin
                        byte2_next = 1'b0;
                        if (shift_reg[0]) begin
                           state_next  = sai_pkg::T_RD;
                           shift_next  = status_word[15:8];
                           byte2_next  = 1'b1;
                           nacked_next = 1'b0;
                           drive_next  = ~status_word[15];
                        end else begin
                           state_next = sai_pkg::T_WR;
                        end
                     end
                  end
               end
            end
            sai_pkg::T_RD: begin
               if (scl_rise && cnt_reg == sai_pkg::ACK_SLOT) begin
                  nacked_next = sda_reg;
               end
               if (scl_fall) begin
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg < sai_pkg::BIT_LAST) begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_next = ~shift_reg[6];
                  end else if (cnt_reg == sai_pkg::BIT_LAST) begin
                     drive_next = 1'b0;                           // controller acks or nacks
                  end else begin
                     cnt_next = 4'h0;
                     if (nacked_reg || !byte2_reg) begin
                        state_next = sai_pkg::T_SKIP;
                     end else begin
                        shift_next = status_word[7:0];
                        byte2_next = 1'b0;
                        drive_next = ~status_word[7];
                     end
                  end
               end
            end
            default: begin
               state_next = sai_pkg::T_IDLE;
               drive_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= sai_pkg::T_IDLE;
         cnt_reg      <= 4'h0;
         shift_reg    <= 8'h00;
         byte2_reg    <= 1'b0;
         cmd_hold_reg <= 8'h00;
         drive_reg    <= 1'b0;
         nacked_reg   <= 1'b0;
         cmd_word_reg <= sai_pkg::STATUS_RESET;
         valid_reg    <= 1'b0;
         load_reg     <= 1'b0;
         srst_reg     <= 1'b0;
         clr_reg      <= 1'b1;                                    // power-up clears
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         shift_reg    <= shift_next;
         byte2_reg    <= byte2_next;
         cmd_hold_reg <= cmd_hold_next;
         drive_reg    <= drive_next;
         nacked_reg   <= nacked_next;
         cmd_word_reg <= cmd_word_next;
         valid_reg    <= valid_next;
         load_reg     <= load_next;
         srst_reg     <= srst_next;
         clr_reg      <= clr_next;
      end
   end

   // open drain: only ever pulls low
   assign bus.sda_tgt_o  = 1'b0;
   assign bus.sda_tgt_oe = drive_reg;
   assign cmd_word         = cmd_word_reg;
   assign cmd_valid        = valid_reg;
   assign load_switch_flag = load_reg;
   assign soft_reset_n_bit = srst_reg;
   assign clear_all        = clr_reg;
endmodule // sai_target

// *** rtl/sai_controller.sv ***
// Purpose: bus controller end: writes a 16-bit word or reads two status bytes
// Assumes: clock line made by dividing clk; target may stretch nothing
// Notes:   one request at a time; busy high until stop done
module sai_controller #(
   parameter logic [7:0] HALF = sai_pkg::HALF_DIV
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rstn,
   // link
   sai_bus_if.controller                  bus,
   // request
   input  wire logic                      req,
   input  wire logic                      req_read,
   input  wire logic [6:0]                req_addr,
   input  wire logic [sai_pkg::WORD_W-1:0] req_wdata,
   // answer
   output logic                           busy,
   output logic                           done,
   output logic                           nack,
   output logic      [sai_pkg::WORD_W-1:0] rdata
);
   sai_pkg::sai_ctl_state_type st_reg, st_next;
   logic [7:0]  div_reg, div_next;
   logic [4:0]  bit_reg, bit_next;     // bit within byte, 0..8
   logic [1:0]  byte_reg, byte_next;
   logic        rd_reg, rd_next;
   logic [23:0] tx_reg, tx_next;
   logic [15:0] rx_reg, rx_next;
   logic        scl_reg, scl_next, sda_reg, sda_next;
   logic        nack_reg, nack_next, done_reg, done_next;
   logic        tick;
   logic        busy_reg, busy_next;
   assign tick = (div_reg == 8'h00);

   always_comb begin
      st_next = st_reg; div_next = tick ? HALF : div_reg - 8'h01;
      bit_next = bit_reg; byte_next = byte_reg; rd_next = rd_reg;
      tx_next = tx_reg; rx_next = rx_reg; scl_next = scl_reg; sda_next = sda_reg;
      nack_next = nack_reg; done_next = 1'b0;
      case (st_reg)
         sai_pkg::C_IDLE: begin
            div_next = HALF; scl_next = 1'b1; sda_next = 1'b1;
            if (req) begin
               st_next = sai_pkg::C_START; rd_next = req_read; nack_next = 1'b0;
               tx_next = {req_addr, req_read, req_wdata};
               bit_next = 5'h00; byte_next = 2'h0;
            end
         end
         sai_pkg::C_START: if (tick) begin
            sda_next = 1'b0; st_next = sai_pkg::C_LOW;
         end
         sai_pkg::C_LOW: if (tick) begin
            if (scl_reg) begin
               scl_next = 1'b0;
            end else begin
               // data set while clock low
               if (bit_reg < 5'h08) begin
                  sda_next = (byte_reg == 2'h0 || !rd_reg) ? tx_reg[23] : 1'b1;
               end else begin
                  sda_next = (byte_reg == 2'h0 || !rd_reg) ? 1'b1 : (byte_reg == 2'h2);
               end
               st_next = sai_pkg::C_HIGH;
            end
         end
         sai_pkg::C_HIGH: if (tick) begin
            if (!scl_reg) begin
               scl_next = 1'b1;
            end else begin
               if (bit_reg < 5'h08) begin
                  tx_next = {tx_reg[22:0], 1'b0};
                  if (rd_reg && byte_reg != 2'h0) rx_next = {rx_reg[14:0], bus.sda_i};
                  bit_next = bit_reg + 5'h01; st_next = sai_pkg::C_LOW;
               end else begin
                  bit_next = 5'h00; byte_next = byte_reg + 2'h1;
                  if ((byte_reg == 2'h0 || !rd_reg) && bus.sda_i) begin
                     nack_next = 1'b1; st_next = sai_pkg::C_STOPA;
                  end else if (byte_reg == 2'h2) begin
                     st_next = sai_pkg::C_STOPA;
                  end else begin
                     st_next = sai_pkg::C_LOW;
                  end
               end
            end
         end
         sai_pkg::C_STOPA: if (tick) begin
            // data drops under a low clock, never together with the clock edge
            if (scl_reg) scl_next = 1'b0;
            else if (sda_reg) sda_next = 1'b0;
            else begin scl_next = 1'b1; st_next = sai_pkg::C_STOPB; end
         end
         sai_pkg::C_STOPB: if (tick) begin
            sda_next = 1'b1; done_next = 1'b1; st_next = sai_pkg::C_IDLE;
         end
         default: st_next = sai_pkg::C_IDLE;
      endcase
      busy_next = (st_next != sai_pkg::C_IDLE);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= sai_pkg::C_IDLE; div_reg <= 8'h00; bit_reg <= 5'h00; byte_reg <= 2'h0;
         rd_reg <= 1'b0; tx_reg <= 24'h00_0000; rx_reg <= 16'h0000;
         scl_reg <= 1'b1; sda_reg <= 1'b1; nack_reg <= 1'b0; done_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         st_reg <= st_next; div_reg <= div_next; bit_reg <= bit_next; byte_reg <= byte_next;
         rd_reg <= rd_next; tx_reg <= tx_next; rx_reg <= rx_next;
         scl_reg <= scl_next; sda_reg <= sda_next; nack_reg <= nack_next; done_reg <= done_next;
         busy_reg <= busy_next;
      end
   end

   assign bus.scl_o      = 1'b0;
   assign bus.scl_oe     = ~scl_reg;
   assign bus.sda_ctl_o  = 1'b0;
   assign bus.sda_ctl_oe = ~sda_reg;
   assign busy = busy_reg;
   assign done = done_reg;
   assign nack = nack_reg;
   assign rdata = rx_reg;
endmodule // sai_controller

// *** verif/sai_target_chk.sv ***
// Purpose: wire-level assertions for the switch array serial link
// Assumes: both ends' enables and line levels visible, sampled by clk
// Notes:   pulse and byte counts are rebuilt from the wire itself
module sai_target_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // link
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_ctl_o,
   input wire logic sda_ctl_oe,
   input wire logic sda_tgt_o,
   input wire logic sda_tgt_oe,
   input wire logic scl_i,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // wire tracking
   // ----
   logic       scl_reg, sda_reg, idle_reg, skip_reg, scl_next, sda_next, idle_next, skip_next;
   logic       start, stop, rise;
   logic [3:0] bitc_reg, bitc_next;
   logic [2:0] bytec_reg, bytec_next;
   logic [7:0] sh_reg, sh_next, adr_reg, adr_next;
   always_comb begin
      start = scl_i && scl_reg && sda_reg && !sda_i;
      stop = scl_i && scl_reg && !sda_reg && sda_i;
      rise = scl_i && !scl_reg;
      scl_next = scl_i;
      sda_next = sda_i;
      {idle_next, skip_next, bitc_next, bytec_next} = {idle_reg, skip_reg, bitc_reg, bytec_reg};
      {sh_next, adr_next} = {sh_reg, adr_reg};
      if (rise) begin
         bitc_next = (bitc_reg == 4'h9) ? 4'h1 : bitc_reg + 4'h1;
         bytec_next = (bitc_reg == 4'h9) ? bytec_reg + 3'h1 : bytec_reg;
         sh_next = {sh_reg[6:0], sda_i};
         if (bitc_reg == 4'h7 && bytec_reg == 3'h0) begin
            adr_next = {sh_reg[6:0], sda_i};
            skip_next = sh_reg[6:2] != sai_pkg::ADDR_FIXED;
         end
      end
      if (start) begin
         {idle_next, skip_next, bitc_next, bytec_next, adr_next} = '0;
      end
      if (stop) begin
         idle_next = 1'b1;
         skip_next = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {scl_reg, sda_reg, idle_reg, skip_reg} <= 4'he;
         {bitc_reg, bytec_reg, sh_reg, adr_reg} <= '0;
      end else begin
         {scl_reg, sda_reg, idle_reg, skip_reg} <= {scl_next, sda_next, idle_next, skip_next};
         {bitc_reg, bytec_reg, sh_reg, adr_reg} <= {bitc_next, bytec_next, sh_next, adr_next};
      end
   end
   // ----
   // assertions
   // ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   chk_clock_ctl_only: assert property ($fell(scl_i) |-> ##[1:12] scl_i)
      else $error("clock line held low, nobody may stretch it");
   chk_start_then_low: assert property (start |-> ##[1:12] !scl_i)
      else $error("no clock low after start");
   chk_tgt_hold_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_tgt_oe))
      else $error("target data changed while clock high");
   chk_mismatch_quiet: assert property (skip_reg |-> !sda_tgt_oe)
      else $error("target drove data after foreign address");
   chk_ack_slot_only: assert property (scl_i && scl_reg && bitc_reg != 4'h9 &&
      !(adr_reg[0] && bytec_reg inside {3'h1, 3'h2}) |-> !sda_tgt_oe)
      else $error("target drove data outside its slots");
   chk_rd_ack_free: assert property (scl_i && scl_reg && bitc_reg == 4'h9 && bytec_reg != 3'h0 &&
      adr_reg[0] |-> !sda_tgt_oe)
      else $error("target drove acknowledge slot of read byte");
   chk_rd_last_nack: assert property (scl_i && scl_reg && bitc_reg == 4'h9 && bytec_reg == 3'h2 &&
      adr_reg[0] |-> sda_i)
      else $error("last read byte acknowledged");
   chk_idle_released: assert property (idle_reg |-> !sda_tgt_oe)
      else $error("target drove data between transfers");
   chk_wr_stop_tenth: assert property ($fell(scl_i) && bitc_reg == 4'h9 && bytec_reg == 3'h2 &&
      !adr_reg[0] |-> ##[1:40] stop)
      else $error("no stop after last write byte");
endmodule // sai_target_chk

// *** verif/sai_target_tb.sv ***
// Purpose: self-checking bench joining controller and target over the link
// Assumes: inputs driven at falling clk edge, default clock divider
// Notes:   driver queues expected results, monitor checks them as they appear
module sai_target_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic        rd;
      logic        nack;
      logic [15:0] data;
   } sai_note_type;
   logic         clk, rstn, req, req_read, addr_select_low, addr_select_high, clr_reg;
   logic         busy, done, nack, cmd_valid, load_switch_flag, soft_reset_n_bit, clear_all;
   logic [6:0]   req_addr;
   logic [15:0]  req_wdata, status_word, rdata, cmd_word, w;
   logic [31:0]  seed;
   int           checks, n_mismatch, n_clear, n_clear_exp;
   sai_note_type note;
   sai_note_type q_ctl[$];
   logic [15:0]  q_tgt[$];
   sai_bus_if bus ();
   sai_controller #(.HALF(sai_pkg::HALF_DIV)) i_sai_controller (.clk(clk), .rstn(rstn), .bus(bus.controller),
      .req(req), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done),
      .nack(nack), .rdata(rdata));
   sai_target i_sai_target (.clk(clk), .rstn(rstn), .bus(bus.target), .addr_select_low(addr_select_low),
      .addr_select_high(addr_select_high), .status_word(status_word), .cmd_word(cmd_word),
      .cmd_valid(cmd_valid), .load_switch_flag(load_switch_flag), .soft_reset_n_bit(soft_reset_n_bit),
      .clear_all(clear_all));
   sai_target_chk i_chk (.clk(clk), .rstn(rstn), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe),
      .sda_ctl_o(bus.sda_ctl_o), .sda_ctl_oe(bus.sda_ctl_oe), .sda_tgt_o(bus.sda_tgt_o),
      .sda_tgt_oe(bus.sda_tgt_oe), .scl_i(bus.scl_i), .sda_i(bus.sda_i));
   // ----
   // helpers
   // ----
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   task automatic summarize;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one whole transfer; entered and left at a falling edge
   task automatic xfer(input logic rd, input logic [6:0] adr, input logic [15:0] wd);
      sai_note_type n;
      logic         hit;
      hit = adr == {sai_pkg::ADDR_FIXED, addr_select_high, addr_select_low};
      n.rd = rd;
      n.nack = ~hit;
      n.data = status_word;
      q_ctl.push_back(n);
      if (hit && !rd) begin
         q_tgt.push_back(wd);
         if (!wd[sai_pkg::SRST_BIT_POS]) n_clear_exp++;
      end
      req = 1'b1;
      req_read = rd;
      req_addr = adr;
      req_wdata = wd;
      @(negedge clk);
      req = 1'b0;
      check(16'(busy), 16'h0001);
      for (int k = 0; k < 4000 && done !== 1'b1; k++) @(negedge clk);
      check(16'(done), 16'h0001);
      check(16'(busy), 16'h0000);
   endtask
   // ----
   // clock, monitor, watchdog
   // ----
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (done === 1'b1) begin
         if (q_ctl.size() == 0) check(16'hffff, 16'h0000);
         else begin
            note = q_ctl.pop_front();
            check(16'(nack), 16'(note.nack));
            if (note.rd && !note.nack) check(rdata, note.data);
         end
      end
      if (cmd_valid === 1'b1) begin
         if (q_tgt.size() == 0) check(16'hffff, 16'h0000);
         else begin
            w = q_tgt.pop_front();
            check(cmd_word, w);
            check(16'({load_switch_flag, soft_reset_n_bit}),
                  16'({w[sai_pkg::LOAD_BIT_POS], w[sai_pkg::SRST_BIT_POS]}));
         end
      end
      if (rstn && clear_all === 1'b1 && !clr_reg) n_clear++;
      clr_reg = clear_all;
   end
   // twenty transfers of at most ~1000 cycles each, doubled for margin
   initial begin
      #2_000_000;
      n_mismatch++;
      summarize;
   end
   // ----
   // main sequence
   // ----
   initial begin
      {rstn, req, req_read, addr_select_low, addr_select_high} = 5'h00;
      req_addr = 7'h00;
      req_wdata = 16'h0000;
      status_word = 16'h0000;
      seed = 32'h0000_000b;
      repeat (12) @(negedge clk);
      check(16'(clear_all), 16'h0001);
      check(16'(soft_reset_n_bit), 16'h0000);
      rstn = 1'b1;
      for (int s = 0; s < 4; s++) begin
         {addr_select_high, addr_select_low} = 2'(s);
         seed = xs(seed);
         // every load and soft-reset combination, back to back
         xfer(1'b0, {sai_pkg::ADDR_FIXED, 2'(s)}, {seed[15:2], 2'(s)});
         xfer(1'b0, {sai_pkg::ADDR_FIXED, 2'(s)}, {seed[31:18], 2'(3 - s)});
         status_word = seed[23:8];
         xfer(1'b1, {sai_pkg::ADDR_FIXED, 2'(s)}, 16'h0000);
         xfer(1'b0, {sai_pkg::ADDR_FIXED, 2'(s + 1)}, seed[15:0]);
         xfer(1'b1, {sai_pkg::ADDR_FIXED ^ (seed[4:0] | 5'h01), 2'(s)}, 16'h0000);
      end
      repeat (20) @(negedge clk);
      check(16'(n_clear), 16'(n_clear_exp));
      check(16'(q_ctl.size() + q_tgt.size()), 16'h0000);
      summarize;
   end
endmodule // sai_target_tb
